// [design/ampg_pkg.sv]
// ampg_pkg: register map, fields, timing and carrier types.
// assumes a 200 MHz clock and 32-bit AXI4-Lite data.
package ampg_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_TARGET_POS = 8'h08;
  localparam logic [7:0] ADDR_VELOCITY = 8'h0C;
  localparam logic [7:0] ADDR_ACCEL = 8'h10;
  localparam logic [7:0] ADDR_DECEL = 8'h14;
  localparam logic [7:0] ADDR_REF_FAST = 8'h18;
  localparam logic [7:0] ADDR_REF_SLOW = 8'h1C;
  localparam logic [7:0] ADDR_REF_ACCEL = 8'h20;
  localparam logic [7:0] ADDR_CURRENT = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h28;
  localparam logic [7:0] ADDR_PROFILE_POS = 8'h2C;
  localparam logic [7:0] ADDR_PROFILE_VEL = 8'h30;
  localparam logic [7:0] ADDR_ENCODER_POS = 8'h34;
  localparam logic [7:0] ADDR_INDEX_POS = 8'h38;

  // control register fields
  localparam int CTRL_CLOSED_LOOP = 0;
  localparam int CTRL_DC_SERVO = 1;
  localparam int CTRL_REF_ZERO = 2;
  localparam int CTRL_SW_LO = 4;
  localparam int CTRL_SW_HI = 5;
  localparam int CTRL_SW_POL_LO = 8;
  localparam int CTRL_SW_POL_HI = 11;

  // command codes
  localparam logic [2:0] CMD_STOP = 3'h0;
  localparam logic [2:0] CMD_MOVE = 3'h1;
  localparam logic [2:0] CMD_VELOCITY = 3'h2;
  localparam logic [2:0] CMD_REFERENCE = 3'h3;
  localparam logic [2:0] CMD_INIT = 3'h4;

  // current register fields
  localparam int CUR_DRIVE_LO = 0;
  localparam int CUR_DRIVE_HI = 6;
  localparam int CUR_HOLD_LO = 8;
  localparam int CUR_HOLD_HI = 14;
  localparam int CUR_RANGE = 16;
  localparam logic [6:0] PERCENT_MAX = 7'h64;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // profile cycle timing
  localparam int CLOCK_MHZ = 200;
  localparam int PROFILE_CYCLE_US = 256;
  localparam int PROFILE_CYCLE_CYCLES = PROFILE_CYCLE_US * CLOCK_MHZ;

  typedef enum logic [2:0] {
    AMPG_IDLE,
    AMPG_MOVE,
    AMPG_VELOCITY,
    AMPG_REF_FAST,
    AMPG_REF_LEAVE,
    AMPG_REF_STOP
  } ampg_mode_t;

  typedef struct packed {
    logic a;
    logic b;
    logic index;
  } ampg_encoder_t;

  typedef struct packed {
    logic stage_release;
    logic current_range_select;
    logic [6:0] drive_current_percent;
    logic [6:0] hold_current_percent;
    logic moving;
    logic step_pulse;
    logic step_dir;
  } ampg_drive_t;

endpackage : ampg_pkg

// [design/ampg_top.sv]
// ampg_top: single-axis profile generator, registers, encoder, current setpoints.
// assumes asynchronous pins and a 200 MHz clock.
//
// Overview of operation
// [RULE_01] destination is a signed 32-bit count, full range
// [RULE_02] velocity and ramp rates are positive, 1 to 2147483647, per cycle
// [RULE_03] point move ramps up at acceleration to programmed velocity
// [RULE_04] after cruise, ramp down at deceleration, stop exactly at destination
// [RULE_05] short moves brake early, giving a triangle
// [RULE_06] accel and decel ramps of a move are symmetric; code ramps up at accel and down at decel, equal only if the two are set equal
// [RULE_07] acceleration applies at start and while speeding up
// [RULE_08] deceleration applies while slowing, until velocity is zero
// [RULE_09] velocity mode takes signed 32-bit velocity; sign picks direction
// [RULE_10] velocity mode has no destination bound
// [RULE_11] velocity mode ramps at set rate to end velocity
// [RULE_12] velocity mode slows on smaller or opposite-sign target
// [RULE_13] reference run drives onto one of four switches, may zero position
// [RULE_14] reference: fast approach, slow leave, reference acceleration, stop
// [RULE_15] decode quadrature channels and optional index into position
// [RULE_16] encoder used only in closed loop; else open-loop stepper
// [RULE_17] two current ranges, low and high, by range select
// [RULE_18] new current range takes effect only at axis initialise
// [RULE_19] stepper keeps drive and hold percentages of selected range
// [RULE_20] dc servo uses drive percentage as current limit
// [RULE_21] jumper fitted releases stage; open follows external release
// [RULE_22] profile recomputed once per 256 microsecond cycle
// [RULE_23] every edge of both channels counts, four per line
// [RULE_24] counter follows phase order, wraps in 32 bits
// [RULE_25] move commands during motion ignored, except velocity updates
`timescale 1ns/100ps
module ampg_top
#(
  parameter int CYCLE_COUNT = ampg_pkg::PROFILE_CYCLE_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ampg_pkg::ampg_encoder_t encoder_pins,
  input wire logic [3:0] limit_switch,
  input wire logic stage_release_jumper,
  input wire logic external_release,
  output ampg_pkg::ampg_drive_t drive
);
  import ampg_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] control;
    logic signed [31:0] target_pos;
    logic signed [31:0] dest;
    logic signed [31:0] velocity;
    logic [31:0] accel;
    logic [31:0] decel;
    logic signed [31:0] ref_fast;
    logic signed [31:0] ref_slow;
    logic [31:0] ref_accel;
    logic [6:0] drive_pct;
    logic [6:0] hold_pct;
    logic range_pending;
    logic range_active;
    ampg_mode_t mode;
    logic [31:0] tick_count;
    logic signed [31:0] prof_pos;
    logic signed [31:0] prof_vel;
    logic signed [31:0] vel_goal;
    logic [31:0] step_accum;
    logic signed [31:0] enc_pos;
    logic signed [31:0] index_pos;
    logic [2:0] enc_meta;
    logic [2:0] enc_sync;
    logic [1:0] enc_prev;
    logic [3:0] sw_meta;
    logic [3:0] sw_sync;
    logic [1:0] rel_meta;
    logic [1:0] rel_sync;
    ampg_drive_t drive;
  } ampg_state_t;

  ampg_state_t state;
  ampg_state_t next_state;

  logic [1:0] sw_index;
  logic switch_hit;
  logic tick;
  logic signed [32:0] remaining;
  logic [32:0] dist_abs;
  logic [32:0] speed_abs;
  logic [63:0] brake_dist;
  logic [31:0] rate;
  logic signed [32:0] vel_next;
  logic signed [32:0] pos_next;
  logic [1:0] enc_now;
  logic [31:0] write_word;

  // byte-lane merge into old value
  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] result;
    result = old;
    for (int i = 0; i < 4; i++)
    begin
      if (state.w_strb[i])
      begin
        result[i*8 +: 8] = state.w_data[i*8 +: 8];
      end
    end
    return result;
  endfunction : merge

  // clamp at full scale
  function automatic logic [6:0] clamp_pct(input logic [6:0] value);
    return (value > PERCENT_MAX) ? PERCENT_MAX : value;
  endfunction : clamp_pct

  always_comb
  begin
    next_state = state;
    sw_index = state.control[CTRL_SW_HI:CTRL_SW_LO];
    switch_hit = state.sw_sync[sw_index] ^ state.control[CTRL_SW_POL_LO + 32'(sw_index)];
    tick = (state.tick_count == 32'(CYCLE_COUNT - 1));
    remaining = 33'(state.dest) - 33'(state.prof_pos);
    dist_abs = remaining[32] ? 33'(-remaining) : remaining;
    speed_abs = state.prof_vel[31] ? 33'(-33'(state.prof_vel)) : 33'(state.prof_vel);
    brake_dist = 64'(speed_abs) * 64'(speed_abs) / (64'(state.decel) << 1);
    rate = state.accel;
    vel_next = 33'(state.prof_vel);
    pos_next = 33'(state.prof_pos);
    enc_now = state.enc_sync[2:1];
    write_word = merge(32'h0);

    // pin synchronisers
    next_state.enc_meta = encoder_pins;
    next_state.enc_sync = state.enc_meta;
    next_state.sw_meta = limit_switch;
    next_state.sw_sync = state.sw_meta;
    next_state.rel_meta = {stage_release_jumper, external_release};
    next_state.rel_sync = state.rel_meta;

    // quadrature decode
    next_state.enc_prev = enc_now;
    if (state.control[CTRL_CLOSED_LOOP]) // see [RULE_16]
    begin
      if (enc_now != state.enc_prev) // see [RULE_23]
      begin
        if ((state.enc_prev[1] ^ enc_now[0]) == 1'b0) // see [RULE_15]
        begin
          next_state.enc_pos = state.enc_pos + 32'h1; // see [RULE_24]
        end
        else if ((state.enc_prev[0] ^ enc_now[1]) == 1'b0)
        begin
          next_state.enc_pos = state.enc_pos - 32'h1; // see [RULE_24]
        end
      end
      if (state.enc_sync[0])
      begin
        next_state.index_pos = state.enc_pos; // see [RULE_15]
      end
    end

    // axi write channel
    if (state.awready && s_axi_awvalid)
    begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
      next_state.awready = 1'b0;
    end
    if (state.wready && s_axi_wvalid)
    begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
      next_state.wready = 1'b0;
    end
    if (state.bvalid && s_axi_bready)
    begin
      next_state.bvalid = 1'b0;
      next_state.awready = 1'b1;
      next_state.wready = 1'b1;
    end

    // profile cycle timebase
    next_state.tick_count = tick ? 32'h0 : state.tick_count + 32'h1; // see [RULE_22]

    // trajectory, once per cycle
    if (tick)
    begin
      case (state.mode)
        AMPG_MOVE:
        begin
          if (brake_dist >= 64'(dist_abs) || (speed_abs > 33'(state.velocity))) // see [RULE_05]
          begin
            rate = state.decel; // see [RULE_08]
            vel_next = remaining[32] ? 33'(state.prof_vel) + 33'(rate) : 33'(state.prof_vel) - 33'(rate);
            if (speed_abs <= 33'(rate) || dist_abs <= speed_abs)
            begin
              vel_next = 33'h0;
            end
          end
          else if (speed_abs < 33'(state.velocity)) // see [RULE_03] see [RULE_07]
          begin
            vel_next = remaining[32] ? 33'(state.prof_vel) - 33'(rate) : 33'(state.prof_vel) + 33'(rate);
            if ((vel_next[32] ? -vel_next : vel_next) > 33'(state.velocity))
            begin
              vel_next = remaining[32] ? -33'(state.velocity) : 33'(state.velocity);
            end
          end
          pos_next = 33'(state.prof_pos) + vel_next;
          if (dist_abs <= (vel_next[32] ? -vel_next : vel_next) || vel_next == 33'h0)
          begin
            pos_next = 33'(state.dest); // see [RULE_04] see [RULE_06]
            vel_next = 33'h0;
            next_state.mode = AMPG_IDLE;
          end
        end
        AMPG_VELOCITY, AMPG_REF_FAST, AMPG_REF_LEAVE, AMPG_REF_STOP:
        begin
          if (state.mode != AMPG_VELOCITY)
          begin
            rate = state.ref_accel; // see [RULE_14]
          end
          // brake against motion
          if (state.prof_vel != 32'sh0 && (state.prof_vel[31] != state.vel_goal[31] ||
              speed_abs > (state.vel_goal[31] ? 33'(-33'(state.vel_goal)) : 33'(state.vel_goal))))
          begin
            if (state.mode == AMPG_VELOCITY)
            begin
              rate = state.decel; // see [RULE_12]
            end
          end
          if (33'(state.vel_goal) > 33'(state.prof_vel))
          begin
            vel_next = 33'(state.prof_vel) + 33'(rate); // see [RULE_11]
            if (vel_next > 33'(state.vel_goal))
            begin
              vel_next = 33'(state.vel_goal);
            end
          end
          else if (33'(state.vel_goal) < 33'(state.prof_vel))
          begin
            vel_next = 33'(state.prof_vel) - 33'(rate);
            if (vel_next < 33'(state.vel_goal))
            begin
              vel_next = 33'(state.vel_goal);
            end
          end
          pos_next = 33'(state.prof_pos) + vel_next; // see [RULE_10]
          if (state.mode == AMPG_REF_FAST && switch_hit) // see [RULE_13]
          begin
            next_state.mode = AMPG_REF_LEAVE;
            next_state.vel_goal = state.ref_slow;
          end
          else if (state.mode == AMPG_REF_LEAVE && !switch_hit)
          begin
            next_state.mode = AMPG_REF_STOP;
            next_state.vel_goal = 32'sh0;
          end
          else if (state.mode == AMPG_REF_STOP && vel_next == 33'h0)
          begin
            next_state.mode = AMPG_IDLE;
            if (state.control[CTRL_REF_ZERO])
            begin
              pos_next = 33'h0; // see [RULE_13]
              next_state.enc_pos = 32'sh0;
            end
          end
        end
        default:
        begin
          vel_next = 33'h0;
        end
      endcase
      next_state.prof_vel = vel_next[31:0];
      next_state.prof_pos = pos_next[31:0];
      next_state.step_accum = state.step_accum + (vel_next[32] ? 32'(-vel_next) : vel_next[31:0]);
    end

    // register writes
    if (state.aw_held && state.w_held && !state.bvalid)
    begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = RESP_OKAY;
      case (state.aw_addr)
        ADDR_CONTROL: next_state.control = merge(state.control);
        ADDR_TARGET_POS: next_state.target_pos = merge(state.target_pos); // see [RULE_01]
        ADDR_VELOCITY: next_state.velocity = merge(state.velocity);
        ADDR_ACCEL: next_state.accel = merge(state.accel); // see [RULE_02]
        ADDR_DECEL: next_state.decel = merge(state.decel);
        ADDR_REF_FAST: next_state.ref_fast = merge(state.ref_fast);
        ADDR_REF_SLOW: next_state.ref_slow = merge(state.ref_slow);
        ADDR_REF_ACCEL: next_state.ref_accel = merge(state.ref_accel);
        ADDR_CURRENT:
        begin
          next_state.drive_pct = clamp_pct(write_word[CUR_DRIVE_HI:CUR_DRIVE_LO]); // see [RULE_19]
          next_state.hold_pct = clamp_pct(write_word[CUR_HOLD_HI:CUR_HOLD_LO]);
          next_state.range_pending = write_word[CUR_RANGE]; // see [RULE_18]
        end
        ADDR_COMMAND:
        begin
          case (write_word[2:0])
            CMD_STOP:
            begin
              next_state.mode = AMPG_IDLE;
              next_state.prof_vel = 32'sh0;
            end
            CMD_MOVE:
            begin
              if (state.mode == AMPG_IDLE) // see [RULE_25]
              begin
                next_state.mode = AMPG_MOVE;
                next_state.dest = state.target_pos;
              end
            end
            CMD_VELOCITY:
            begin
              if (state.mode == AMPG_IDLE || state.mode == AMPG_VELOCITY) // see [RULE_25]
              begin
                next_state.mode = AMPG_VELOCITY;
                next_state.vel_goal = state.velocity; // see [RULE_09]
              end
            end
            CMD_REFERENCE:
            begin
              if (state.mode == AMPG_IDLE)
              begin
                next_state.mode = AMPG_REF_FAST;
                next_state.vel_goal = state.ref_fast; // see [RULE_14]
              end
            end
            CMD_INIT:
            begin
              if (state.mode == AMPG_IDLE)
              begin
                next_state.range_active = state.range_pending; // see [RULE_18]
              end
            end
            default:
            begin
              next_state.bresp = RESP_SLVERR;
            end
          endcase
        end
        default: next_state.bresp = RESP_SLVERR;
      endcase
    end

    // axi read channel
    if (state.arready && s_axi_arvalid)
    begin
      next_state.arready = 1'b0;
      next_state.rvalid = 1'b1;
      next_state.rresp = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CONTROL: next_state.rdata = state.control;
        ADDR_COMMAND: next_state.rdata = 32'h0;
        ADDR_TARGET_POS: next_state.rdata = state.target_pos;
        ADDR_VELOCITY: next_state.rdata = state.velocity;
        ADDR_ACCEL: next_state.rdata = state.accel;
        ADDR_DECEL: next_state.rdata = state.decel;
        ADDR_REF_FAST: next_state.rdata = state.ref_fast;
        ADDR_REF_SLOW: next_state.rdata = state.ref_slow;
        ADDR_REF_ACCEL: next_state.rdata = state.ref_accel;
        ADDR_CURRENT: next_state.rdata = {15'h0, state.range_pending, 1'b0, state.hold_pct, 1'b0, state.drive_pct};
        ADDR_STATUS: next_state.rdata = {22'h0, state.range_active, state.sw_sync, 1'b0, 1'(state.mode != AMPG_IDLE),
                                        state.mode};
        ADDR_PROFILE_POS: next_state.rdata = state.prof_pos;
        ADDR_PROFILE_VEL: next_state.rdata = state.prof_vel;
        ADDR_ENCODER_POS: next_state.rdata = state.enc_pos;
        ADDR_INDEX_POS: next_state.rdata = state.index_pos;
        default:
        begin
          next_state.rdata = 32'h0;
          next_state.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (state.rvalid && s_axi_rready)
    begin
      next_state.rvalid = 1'b0;
      next_state.arready = 1'b1;
    end

    // power-stage outputs
    next_state.drive.stage_release = state.rel_sync[1] | state.rel_sync[0]; // see [RULE_21]
    next_state.drive.current_range_select = state.range_active; // see [RULE_17]
    next_state.drive.drive_current_percent = state.drive_pct; // see [RULE_20]
    next_state.drive.hold_current_percent = state.control[CTRL_DC_SERVO] ? 7'h0 : state.hold_pct; // see [RULE_19]
    next_state.drive.moving = (state.mode != AMPG_IDLE);
    next_state.drive.step_dir = ~state.prof_vel[31];
    next_state.drive.step_pulse = state.step_accum[0];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= '0;
      state.awready <= 1'b1;
      state.wready <= 1'b1;
      state.arready <= 1'b1;
      state.mode <= AMPG_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bresp = state.bresp;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_arready = state.arready;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign s_axi_rvalid = state.rvalid;
  assign drive = state.drive;

endmodule : ampg_top

// [tb/ampg_chk.sv]
// ampg_chk: port-level assertions for ampg_top.
// assumes a bind to ampg_top; one clock domain.
`timescale 1ns/100ps
module ampg_chk
  import ampg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stage_release_jumper,
  input wire logic external_release,
  input wire ampg_pkg::ampg_drive_t drive
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_bresp_stands: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_jumper_release: assert property (stage_release_jumper [*6] |-> drive.stage_release)
    else $error("stage not released by jumper");
  a_ext_release: assert property ((!stage_release_jumper && external_release) [*6] |-> drive.stage_release)
    else $error("stage not released by input");
  a_ext_hold: assert property ((!stage_release_jumper && !external_release) [*6] |-> !drive.stage_release)
    else $error("stage released without cause");
  a_pct_clamp: assert property (drive.drive_current_percent <= PERCENT_MAX && drive.hold_current_percent <= PERCENT_MAX)
    else $error("current percent above full scale");
endmodule : ampg_chk

// [tb/ampg_motor.sv]
// ampg_motor: power stage, limit switch and encoder model.
// assumes one count per cycle while moving; bench jogs the encoder.
`timescale 1ns/100ps
module ampg_motor
  import ampg_pkg::*;
(
  input wire logic clock,
  input wire ampg_pkg::ampg_drive_t drive,
  input wire logic jog,
  input wire logic jog_up,
  input wire logic signed [31:0] switch_at,
  output ampg_pkg::ampg_encoder_t encoder_pins,
  output logic [3:0] limit_switch
);
  logic signed [31:0] mpos = 32'sh0;
  logic [31:0] epos = 32'h0;
  always @(posedge clock)
  begin
    if (drive.moving)
      mpos <= drive.step_dir ? mpos + 1 : mpos - 1;
    if (jog)
      epos <= jog_up ? epos + 1 : epos - 1;
  end
  // channel a leads counting up
  assign encoder_pins.a = epos[1] ^ epos[0];
  assign encoder_pins.b = epos[1];
  assign encoder_pins.index = (epos[5:0] == 6'h00);
  assign limit_switch = {3'h0, mpos < switch_at};
endmodule : ampg_motor

// [tb/ampg_top_tb.sv]
// ampg_top_tb: self-checking bench for ampg_top.
// assumes CYCLE_COUNT of 8 and the motor model on the pins.
`timescale 1ns/100ps
module ampg_top_tb;
  import ampg_pkg::*;
  typedef struct packed {logic [31:0] m; logic [31:0] d; logic [1:0] r;} ampg_note_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  ampg_encoder_t encoder_pins;
  ampg_drive_t drive;
  logic [3:0] limit_switch;
  logic stage_release_jumper = 1'b0, external_release = 1'b0, jog = 1'b0, jog_up = 1'b1;
  logic signed [31:0] switch_at = 32'sh80000000;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  logic [31:0] seed = 32'h38;
  ampg_note_t rq[$];
  logic [1:0] bq[$];
  ampg_top #(.CYCLE_COUNT(8)) i_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .encoder_pins,
    .limit_switch, .stage_release_jumper, .external_release, .drive);
  ampg_motor i_motor (.clock, .drive, .jog, .jog_up, .switch_at, .encoder_pins, .limit_switch);
  initial
    forever #2.5 clock = ~clock;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic final_report();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFFFFFFFF,
    input logic [1:0] r = RESP_OKAY);
    rq.push_back('{m, d & m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask : rd
  task automatic jog_n(input logic [31:0] n, input logic up);
    repeat (n)
    begin
      jog <= 1'b1;
      jog_up <= up;
      @(posedge clock);
      jog <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask : jog_n
  task automatic wait_idle();
    repeat (4) @(posedge clock);
    while (drive.moving !== 1'b0) @(posedge clock);
  endtask : wait_idle
  always @(posedge clock)
  begin
    ampg_note_t n;
    cycles++;
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      cmp({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
    begin
      n = rq.pop_front();
      cmp(s_axi_rdata & n.m, n.d);
      cmp({30'h0, s_axi_rresp}, {30'h0, n.r});
    end
    if (cycles == 60000)
    begin
      miscompares++;
      final_report();
    end
  end
  initial
  begin
    logic [31:0] t, r;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(ADDR_STATUS, 32'h0, 32'h20F);
    rd(8'h3C, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h3C, 32'h5, RESP_SLVERR);
    wr(ADDR_COMMAND, 32'h7, RESP_SLVERR);
    $display("test registers done");
    wr(ADDR_CURRENT, 32'h00017832);
    repeat (2) @(posedge clock);
    cmp({31'h0, drive.current_range_select}, 32'h0);
    cmp({25'h0, drive.drive_current_percent}, 32'h32);
    cmp({25'h0, drive.hold_current_percent}, 32'h64);
    wr(ADDR_COMMAND, 32'(CMD_INIT));
    repeat (2) @(posedge clock);
    cmp({31'h0, drive.current_range_select}, 32'h1);
    wr(ADDR_CONTROL, 32'h2);
    repeat (2) @(posedge clock);
    cmp({18'h0, drive.drive_current_percent, drive.hold_current_percent}, 32'h1900);
    wr(ADDR_CONTROL, 32'h0);
    $display("test current done");
    wr(ADDR_VELOCITY, 32'h8);
    wr(ADDR_ACCEL, 32'h2);
    wr(ADDR_DECEL, 32'h2);
    t = 32'h0;
    for (int i = 0; i < 3; i++)
    begin
      r = rnd() & 32'hFF;
      t = (i == 1) ? t + 32'hA : (i == 0) ? t + 32'h40 + r : t - 32'h40 - r;
      wr(ADDR_TARGET_POS, t);
      wr(ADDR_COMMAND, 32'(CMD_MOVE));
      if (i == 2)
      begin
        wr(ADDR_TARGET_POS, t + 32'h100);
        wr(ADDR_COMMAND, 32'(CMD_MOVE));
        cmp({31'h0, drive.step_dir}, 32'h0);
      end
      wait_idle();
      rd(ADDR_PROFILE_POS, t);
    end
    $display("test move done");
    switch_at <= i_motor.mpos - 32'h20;
    wr(ADDR_REF_FAST, 32'hFFFFFFF8);
    wr(ADDR_REF_SLOW, 32'h2);
    wr(ADDR_REF_ACCEL, 32'h2);
    wr(ADDR_CONTROL, 32'h4);
    wr(ADDR_COMMAND, 32'(CMD_REFERENCE));
    wait_idle();
    rd(ADDR_PROFILE_POS, 32'h0, 32'hFFFFFFF0);
    $display("test reference done");
    wr(ADDR_VELOCITY, 32'hFFFFFFFA);
    wr(ADDR_COMMAND, {29'h0, CMD_VELOCITY});
    repeat (200) @(posedge clock);
    rd(ADDR_PROFILE_VEL, 32'hFFFFFFFA);
    cmp({31'h0, drive.step_dir}, 32'h0);
    rd(ADDR_STATUS, {29'h0, AMPG_VELOCITY}, 32'h7);
    wr(ADDR_VELOCITY, 32'h0);
    wr(ADDR_COMMAND, 32'(CMD_VELOCITY));
    repeat (200) @(posedge clock);
    rd(ADDR_PROFILE_VEL, 32'h0);
    wr(ADDR_COMMAND, 32'(CMD_STOP));
    $display("test velocity done");
    jog_n(32'h8, 1'b1);
    rd(ADDR_ENCODER_POS, 32'h0);
    wr(ADDR_CONTROL, 32'h1);
    r = (rnd() & 32'h1F) + 32'h4;
    jog_n(r, 1'b1);
    jog_n(32'h3, 1'b0);
    rd(ADDR_ENCODER_POS, r - 32'h3);
    external_release <= 1'b1;
    repeat (10) @(posedge clock);
    stage_release_jumper <= 1'b1;
    repeat (10) @(posedge clock);
    $display("test encoder done");
    final_report();
  end
endmodule : ampg_top_tb
bind ampg_top ampg_chk i_chk (.clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .stage_release_jumper, .external_release, .drive);
